/* File: common/dgc_pkg.sv */
// Register map, field layout, reset values and types of the digitizer
// acquisition control block.
// Assumes one clock, pclk, that also serves as the acquisition clock.
package dgc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Register byte addresses.
  localparam logic [11:0] A_MODE = 12'h000;
  localparam logic [11:0] A_CLK  = 12'h004;
  localparam logic [11:0] A_CHAN = 12'h008;
  localparam logic [11:0] A_OFS  = 12'h00C;
  localparam logic [11:0] A_DIO  = 12'h010;
  localparam logic [11:0] A_STAT = 12'h014;
  localparam logic [11:0] A_TSL  = 12'h018;
  localparam logic [11:0] A_TSH  = 12'h01C;
  localparam logic [11:0] A_TCL  = 12'h020;
  localparam logic [11:0] A_TCH  = 12'h024;
  localparam logic [11:0] A_WCNT = 12'h028;

  // Field positions.
  localparam int CLK_EXT_B  = 0;
  localparam int CLK_REFI_B = 1;
  localparam int CLK_REFX_B = 2;
  localparam int DIV_LSB    = 3;
  localparam int DSC_LSB    = 8;
  localparam int CH_DUAL_B  = 0;
  localparam int CH_SEL_B   = 1;
  localparam int GAIN0_LSB  = 4;
  localparam int GAIN1_LSB  = 8;
  localparam int OFS1_LSB   = 16;
  localparam int DIO_IN_B   = 0;
  localparam int DIO_SEL_LSB = 1;
  localparam int ST_RDONE_B = 5;
  localparam int ST_TSREQ_B = 6;
  localparam int ST_LOCK_B  = 7;

  // Limits and counts.
  localparam logic [4:0] DIV_MIN  = 5'h01;
  localparam logic [4:0] DIV_MAX  = 5'h14;
  localparam logic [2:0] DSC_MAX  = 3'h5;
  localparam logic [2:0] GAIN_MAX = 3'h5;
  localparam logic [5:0] THR_SLOTS = 6'h08;
  localparam logic [5:0] PKT_WORDS = 6'h10;

  typedef enum logic [4:0] {
    M_STBY = 5'h01,
    M_RAM  = 5'h02,
    M_XFER = 5'h04,
    M_BUF  = 5'h08,
    M_OFFL = 5'h10
  } dgc_mode_e;

  localparam logic [1:0] DIO_LOW  = 2'h0;
  localparam logic [1:0] DIO_TRIG = 2'h1;
  localparam logic [1:0] DIO_CLK2 = 2'h2;
  localparam logic [1:0] DIO_HIGH = 2'h3;

  typedef struct packed {
    logic        clk_ext;
    logic        clkin_ref;
    logic        ref_ext;
    logic [4:0]  div;
    logic [2:0]  dsc;
    logic        dual;
    logic        sel;
    logic [2:0]  gain0;
    logic [2:0]  gain1;
    logic [11:0] ofs0;
    logic [11:0] ofs1;
    logic        dio_in;
    logic [1:0]  dio_sel;
  } dgc_cfg_s;

  localparam dgc_cfg_s CFG_RST = '{div: DIV_MIN, dual: 1'b1,
                                   dio_in: 1'b1, default: '0};

  typedef struct packed {
    logic [13:0] ch0;
    logic [13:0] ch1;
  } dgc_smp_s;
endpackage : dgc_pkg

/* File: rtl/dgc_sync.sv */
// Three-stage synchroniser for a pin, with an agreement filter.
// Assumes the pin toggles far slower than pclk; faster edges are missed.
`timescale 1ns/1ps
module dgc_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and filtered result
  input  wire logic pin,
  output logic      lvl,
  output logic      rise
);
  import dgc_pkg::*;

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
  } dgc_sync_s;

  dgc_sync_s st_r;
  dgc_sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sh = {st_r.sh[1:0], pin};
    st_nxt.rise = 1'b0;
    if (st_r.sh[2] == st_r.sh[1] && st_r.sh[1] != st_r.lvl) begin
      st_nxt.lvl = st_r.sh[1];
      st_nxt.rise = st_r.sh[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lvl = st_r.lvl;
  assign rise = st_r.rise;
endmodule : dgc_sync

/* File: rtl/dgc_div.sv */
// Event divider: counts ticks in groups of ratio and flags the first and
// last tick of each group. A ratio of zero acts as one.
`timescale 1ns/1ps
module dgc_div (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [5:0] ratio,
  // Group marks
  output logic            first,
  output logic            last
);
  import dgc_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
  } dgc_div_s;

  dgc_div_s st_r;
  dgc_div_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    first = tick && st_r.cnt == 6'h00;
    last = tick && (st_r.cnt + 6'h01 >= ratio);
    if (clr) begin
      st_nxt.cnt = 6'h00;
    end else if (tick) begin
      st_nxt.cnt = last ? 6'h00 : st_r.cnt + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : dgc_div

/* File: rtl/dgc_top.sv */
// Acquisition control: APB registers, clock selection, sample thinning,
// packing, operating modes, memory interleave and host stream.
// Assumes pclk is the acquisition clock and the ADC answers adc_conv.
// Functional notes
// - External clock is divided by an integer from 1 to 20.
// - Samples may be discarded at ratios 1, 2, 4, 8, 16, 32.
// - Dual or single channel capture; single picks channel one or two.
// - Connector output: low, synced trigger, clock over two, or high.
// - Connector as input: each pulse requests a timestamp.
// - Clock connector feeds the ADC or the synthesizer reference.
// - Synthesizer reference is internal or external, as selected.
// - Standby moves no data.
// - RAM acquisition writes memory only, nothing to the host.
// - Transfer mode reads memory out, only after a finished capture.
// - Buffered mode captures and streams, memory used as FIFO.
// - Offload mode sends samples out and streams the result back.
// - Buffered mode alternates write and read packets; reads keep to read packets, writes do not.
// - Each 14-bit sample takes one 16-bit word.
// - Host stream is held to seven eighths of the pclk slots.
// - Each channel has a 12-bit offset code.
// - Each channel selects one of six gain ranges.
// - Leaving standby clears the timestamp; it counts acquisition ticks.
`timescale 1ns/1ps
module dgc_top #(
  parameter logic [27:0] ACTIVE_WORDS = 28'h8000000
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Clock tree and front end
  input  wire logic              synth_tick,
  input  wire logic              synth_locked,
  input  wire logic              ext_clk_pin,
  output dgc_pkg::dgc_cfg_s      fe_cfg,
  output logic                   adc_conv,
  // Converter samples
  input  wire logic              adc_valid,
  input  wire dgc_pkg::dgc_smp_s adc_smp,
  // Trigger and digital connector
  input  wire logic              trig_pin,
  input  wire logic              dio_i,
  output logic                   dio_o,
  output logic                   dio_oe,
  // Sample memory
  output logic                   mem_wr_valid,
  output logic [31:0]            mem_wr_data,
  output logic                   mem_wr_pkt,
  input  wire logic              mem_rd_valid,
  input  wire logic [31:0]       mem_rd_data,
  output logic                   mem_rd_ready,
  // Processing offload device
  output logic                   offload_tx_valid,
  output logic [31:0]            offload_tx_data,
  input  wire logic              offload_rx_valid,
  input  wire logic [31:0]       offload_rx_data,
  output logic                   offload_rx_ready,
  // Host stream
  output logic                   host_valid,
  output logic [31:0]            host_data,
  input  wire logic              host_ready,
  // Status
  output dgc_pkg::dgc_mode_e     mode
);
  import dgc_pkg::*;

  typedef struct packed {
    dgc_mode_e   state;
    dgc_cfg_s    cfg;
    dgc_cfg_s    act;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [63:0] ts;
    logic [63:0] tcap;
    logic        ts_pend;
    logic        rdone;
    logic [27:0] wr_cnt;
    logic [27:0] rd_cnt;
    logic        half;
    logic [15:0] lo;
    logic        mem_wr_valid;
    logic [31:0] mem_wr_data;
    logic        mem_wr_pkt;
    logic        mem_rd_ready;
    logic        tx_valid;
    logic [31:0] tx_data;
    logic        rx_ready;
    logic        host_valid;
    logic [31:0] host_data;
    logic        adc_conv;
    logic        clk2;
    logic        dio_o;
    logic        dio_oe;
  } dgc_st_s;

  localparam dgc_st_s ST_RST = '{state: M_STBY, cfg: CFG_RST,
                                 act: CFG_RST, default: '0};

  dgc_st_s st_r;
  dgc_st_s st_nxt;

  logic ext_rise;
  logic dio_rise;
  logic trig_lvl;
  logic ext_first;
  logic dsc_first;
  logic thr_blk;
  logic pkt_last;
  logic acq_tick;
  logic capturing;

  // The external clock is sampled, so it must run well below pclk.
  dgc_sync u_ext_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (ext_clk_pin),
    .lvl     (),
    .rise    (ext_rise)
  );

  dgc_sync u_dio_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (dio_i),
    .lvl     (),
    .rise    (dio_rise)
  );

  dgc_sync u_trig_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (trig_pin),
    .lvl     (trig_lvl),
    .rise    ()
  );

  dgc_div u_ext_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (st_r.state == M_STBY),
    .tick    (ext_rise),
    .ratio   ({1'b0, st_r.act.div}),
    .first   (ext_first),
    .last    ()
  );

  dgc_div u_dsc_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (!capturing),
    .tick    (adc_valid),
    .ratio   (6'(6'h01 << st_r.act.dsc)),
    .first   (dsc_first),
    .last    ()
  );

  dgc_div u_thr_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (1'b0),
    .tick    (1'b1),
    .ratio   (THR_SLOTS),
    .first   (thr_blk),
    .last    ()
  );

  dgc_div u_pkt_div (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (st_r.state != M_BUF),
    .tick    (1'b1),
    .ratio   (PKT_WORDS),
    .first   (),
    .last    (pkt_last)
  );

  assign acq_tick = st_r.act.clk_ext ? ext_first : synth_tick;
  assign capturing = st_r.state inside {M_RAM, M_BUF, M_OFFL};

  always_comb begin
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd;
    logic        wv;
    logic [31:0] word;
    logic [13:0] s;
    logic [27:0] fill;
    acc = psel && penable;
    wr = acc && st_r.pready && pwrite;
    hit = 1'b1;
    rd = 32'h0000_0000;
    wv = 1'b0;
    word = 32'h0000_0000;
    s = st_r.act.sel ? adc_smp.ch1 : adc_smp.ch0;
    fill = st_r.wr_cnt - st_r.rd_cnt;
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.mem_wr_valid = 1'b0;
    st_nxt.tx_valid = 1'b0;
    st_nxt.adc_conv = acq_tick;

    // Register read, answered one cycle into the access phase.
    unique case (paddr)
      A_MODE: rd = {27'h0, st_r.state};
      A_CLK: rd = {21'h0, st_r.cfg.dsc, st_r.cfg.div, st_r.cfg.ref_ext,
                   st_r.cfg.clkin_ref, st_r.cfg.clk_ext};
      A_CHAN: rd = {21'h0, st_r.cfg.gain1, 1'b0, st_r.cfg.gain0,
                    2'h0, st_r.cfg.sel, st_r.cfg.dual};
      A_OFS: rd = {4'h0, st_r.cfg.ofs1, 4'h0, st_r.cfg.ofs0};
      A_DIO: rd = {29'h0, st_r.cfg.dio_sel, st_r.cfg.dio_in};
      A_STAT: rd = {24'h0, synth_locked, st_r.ts_pend, st_r.rdone,
                    st_r.state};
      A_TSL: rd = st_r.ts[31:0];
      A_TSH: rd = st_r.ts[63:32];
      A_TCL: rd = st_r.tcap[31:0];
      A_TCH: rd = st_r.tcap[63:32];
      A_WCNT: rd = {4'h0, st_r.wr_cnt};
      default: hit = 1'b0;
    endcase
    if (acc && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = !hit;
      st_nxt.prdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
    end

    // Configuration writes land in the shadow copy.
    if (wr && paddr == A_CLK) begin
      st_nxt.cfg.clk_ext = pwdata[CLK_EXT_B];
      st_nxt.cfg.clkin_ref = pwdata[CLK_REFI_B];
      st_nxt.cfg.ref_ext = pwdata[CLK_REFX_B];
      st_nxt.cfg.div = pwdata[DIV_LSB +: 5];
      if (pwdata[DIV_LSB +: 5] < DIV_MIN) begin
        st_nxt.cfg.div = DIV_MIN;
      end else if (pwdata[DIV_LSB +: 5] > DIV_MAX) begin
        st_nxt.cfg.div = DIV_MAX;
      end
      st_nxt.cfg.dsc = pwdata[DSC_LSB +: 3];
      if (pwdata[DSC_LSB +: 3] > DSC_MAX) begin
        st_nxt.cfg.dsc = DSC_MAX;
      end
    end
    if (wr && paddr == A_CHAN) begin
      st_nxt.cfg.dual = pwdata[CH_DUAL_B];
      st_nxt.cfg.sel = pwdata[CH_SEL_B];
      st_nxt.cfg.gain0 = pwdata[GAIN0_LSB +: 3];
      st_nxt.cfg.gain1 = pwdata[GAIN1_LSB +: 3];
      if (pwdata[GAIN0_LSB +: 3] > GAIN_MAX) begin
        st_nxt.cfg.gain0 = GAIN_MAX;
      end
      if (pwdata[GAIN1_LSB +: 3] > GAIN_MAX) begin
        st_nxt.cfg.gain1 = GAIN_MAX;
      end
    end
    if (wr && paddr == A_OFS) begin
      st_nxt.cfg.ofs0 = pwdata[11:0];
      st_nxt.cfg.ofs1 = pwdata[OFS1_LSB +: 12];
    end
    if (wr && paddr == A_DIO) begin
      st_nxt.cfg.dio_in = pwdata[DIO_IN_B];
      st_nxt.cfg.dio_sel = pwdata[DIO_SEL_LSB +: 2];
    end
    // A running capture never sees a half-written setup.
    if (st_r.state == M_STBY) begin
      st_nxt.act = st_r.cfg;
    end

    // Timestamp requests; a pulse in the clearing cycle survives.
    if (wr && paddr == A_STAT && pwdata[ST_TSREQ_B]) begin
      st_nxt.ts_pend = 1'b0;
    end
    if (dio_rise && st_r.act.dio_in) begin
      st_nxt.ts_pend = 1'b1;
      st_nxt.tcap = st_r.ts;
    end

    // Connector output and clock over two.
    if (acq_tick) begin
      st_nxt.clk2 = !st_r.clk2;
    end
    st_nxt.dio_oe = !st_r.act.dio_in;
    unique case (st_r.act.dio_sel)
      DIO_LOW: st_nxt.dio_o = 1'b0;
      DIO_TRIG: st_nxt.dio_o = trig_lvl;
      DIO_CLK2: st_nxt.dio_o = st_r.clk2;
      DIO_HIGH: st_nxt.dio_o = 1'b1;
    endcase

    // Sample thinning and packing into 16-bit words.
    if (capturing && adc_valid && dsc_first) begin
      if (st_r.act.dual) begin
        wv = 1'b1;
        word = {2'h0, adc_smp.ch1, 2'h0, adc_smp.ch0};
      end else if (!st_r.half) begin
        st_nxt.half = 1'b1;
        st_nxt.lo = {2'h0, s};
      end else begin
        st_nxt.half = 1'b0;
        wv = 1'b1;
        word = {2'h0, s, st_r.lo};
      end
    end
    if (wv && st_r.state == M_OFFL) begin
      st_nxt.tx_valid = 1'b1;
      st_nxt.tx_data = word;
    end else if (wv && fill != ACTIVE_WORDS) begin
      st_nxt.mem_wr_valid = 1'b1;
      st_nxt.mem_wr_data = word;
      st_nxt.wr_cnt = st_r.wr_cnt + 28'h0000001;
      if (st_r.state == M_RAM &&
          st_r.wr_cnt + 28'h0000001 == ACTIVE_WORDS) begin
        st_nxt.rdone = 1'b1;
        st_nxt.state = M_STBY;
      end
    end

    // Host stream fed from memory or from the offload device.
    if (host_ready && st_r.host_valid) begin
      st_nxt.host_valid = 1'b0;
    end
    if (mem_rd_valid && st_r.mem_rd_ready) begin
      st_nxt.host_valid = 1'b1;
      st_nxt.host_data = mem_rd_data;
      st_nxt.rd_cnt = st_r.rd_cnt + 28'h0000001;
      if (st_r.state == M_XFER &&
          st_r.rd_cnt + 28'h0000001 == st_r.wr_cnt) begin
        st_nxt.state = M_STBY;
      end
    end
    if (offload_rx_valid && st_r.rx_ready) begin
      st_nxt.host_valid = 1'b1;
      st_nxt.host_data = offload_rx_data;
    end

    // Mode changes; leaving a mode is allowed, entering only from standby.
    if (wr && paddr == A_MODE) begin
      unique case (pwdata[4:0])
        M_STBY: st_nxt.state = M_STBY;
        M_RAM, M_BUF, M_OFFL: begin
          if (st_r.state == M_STBY) begin
            st_nxt.state = dgc_mode_e'(pwdata[4:0]);
            st_nxt.wr_cnt = 28'h0000000;
            st_nxt.rd_cnt = 28'h0000000;
            st_nxt.rdone = 1'b0;
            st_nxt.half = 1'b0;
          end
        end
        M_XFER: begin
          if (st_r.state == M_STBY && st_r.rdone) begin
            st_nxt.state = M_XFER;
            st_nxt.rd_cnt = 28'h0000000;
          end
        end
        default: ;
      endcase
    end

    if (st_r.state == M_STBY && st_nxt.state != M_STBY) begin
      st_nxt.ts = 64'h0;
    end else if (st_r.state != M_STBY && acq_tick) begin
      st_nxt.ts = st_r.ts + 64'h1;
    end

    // Buffered mode swaps packet direction every packet slot.
    if (st_nxt.state != M_BUF) begin
      st_nxt.mem_wr_pkt = st_nxt.state == M_RAM;
    end else if (pkt_last) begin
      st_nxt.mem_wr_pkt = !st_r.mem_wr_pkt;
    end
    // One slot in eight is withheld to stay under the host link rate.
    st_nxt.mem_rd_ready = (st_nxt.state == M_XFER ||
                           (st_nxt.state == M_BUF && !st_nxt.mem_wr_pkt)) &&
                          st_nxt.rd_cnt != st_nxt.wr_cnt &&
                          !st_nxt.host_valid && !thr_blk;
    st_nxt.rx_ready = st_nxt.state == M_OFFL &&
                      !st_nxt.host_valid && !thr_blk;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign fe_cfg = st_r.act;
  assign adc_conv = st_r.adc_conv;
  assign dio_o = st_r.dio_o;
  assign dio_oe = st_r.dio_oe;
  assign mem_wr_valid = st_r.mem_wr_valid;
  assign mem_wr_data = st_r.mem_wr_data;
  assign mem_wr_pkt = st_r.mem_wr_pkt;
  assign mem_rd_ready = st_r.mem_rd_ready;
  assign offload_tx_valid = st_r.tx_valid;
  assign offload_tx_data = st_r.tx_data;
  assign offload_rx_ready = st_r.rx_ready;
  assign host_valid = st_r.host_valid;
  assign host_data = st_r.host_data;
  assign mode = st_r.state;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_leave_stby;
    st_r.state == M_STBY ##1 st_r.state != M_STBY;
  endsequence

  sequence s_held_active;
    st_r.state != M_STBY ##1 st_r.state != M_STBY;
  endsequence

  a_stby_quiet: assert property (
    $past(st_r.state) == M_STBY && st_r.state == M_STBY |->
      !mem_wr_valid && !offload_tx_valid && !mem_rd_ready)
    else $error("data moved in standby");
  a_ram_no_host: assert property (
    st_r.state == M_RAM |-> !mem_rd_ready && !offload_rx_ready)
    else $error("host fed during RAM capture");
  a_xfer_after_done: assert property (
    $rose(st_r.state == M_XFER) |-> $past(st_r.rdone))
    else $error("transfer started without finished capture");
  a_ts_cleared: assert property (
    s_leave_stby |-> st_r.ts == 64'h0)
    else $error("timestamp not cleared on start");
  a_ts_counts: assert property (
    s_held_active ##0 $past(acq_tick) |-> st_r.ts == $past(st_r.ts) + 64'h1)
    else $error("timestamp missed an acquisition tick");
  a_cfg_frozen: assert property (
    s_held_active |-> $stable(st_r.act))
    else $error("setup changed during acquisition");
  a_dio_high: assert property (
    $past(st_r.act.dio_sel) == DIO_HIGH |-> dio_o)
    else $error("connector not high");
  a_ts_request: assert property (
    dio_rise && st_r.act.dio_in |=> st_r.ts_pend &&
      st_r.tcap == $past(st_r.ts))
    else $error("timestamp request lost");
  a_host_rate: assert property (
    mem_rd_ready [*7] |=> !mem_rd_ready)
    else $error("host slots not throttled");
  a_pkt_split: assert property (
    st_r.state == M_BUF && mem_wr_pkt |-> !mem_rd_ready)
    else $error("read issued in a write packet");
  a_offload_route: assert property (
    $past(st_r.state) == M_OFFL && st_r.state == M_OFFL |-> !mem_wr_valid)
    else $error("offload samples went to memory");
  a_div_range: assert property (
    st_r.act.div >= DIV_MIN && st_r.act.div <= DIV_MAX &&
      st_r.act.dsc <= DSC_MAX && st_r.act.gain0 <= GAIN_MAX)
    else $error("divisor, ratio or gain out of range");
endmodule : dgc_top

/* File: verification/dgc_host_model.sv */
// Host end of the outbound stream: accepts words and counts them.
// Assumes host_valid and host_data hold until host_ready is seen high.
`timescale 1ns/1ps
module dgc_host_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Stream
  input  wire logic        slow,
  input  wire logic        host_valid,
  input  wire logic [31:0] host_data,
  output logic             host_ready,
  // Record
  output logic [7:0]       n_rx,
  output logic [31:0]      last
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ready <= 1'b0;
      n_rx       <= 8'h00;
      last       <= 32'h0;
    end else begin
      // A stalling host exposes words that are lost or sent twice.
      host_ready <= slow ? ~host_ready : 1'b1;
      if (host_valid && host_ready) begin
        n_rx <= n_rx + 8'h01;
        last <= host_data;
      end
    end
  end
endmodule : dgc_host_model

/* File: verification/dgc_top_tb.sv */
// Testbench of the acquisition control: APB sequences with expected values.
// Assumes a memory that always has data and a slow host stream sink.
`timescale 1ns/1ps
module dgc_top_tb;
  import dgc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_wr_data, host_data, last, q;
  logic        synth_tick, synth_locked, ext_clk_pin, adc_valid, trig_pin;
  logic        dio_i, dio_o, dio_oe, mem_wr_valid, mem_rd_valid;
  logic        mem_rd_ready, offload_rx_valid, host_valid, host_ready;
  logic [31:0] offload_rx_data;
  logic [7:0]  n_rx;
  dgc_smp_s    adc_smp;
  dgc_cfg_s    fe_cfg;
  dgc_mode_e   mode;
  int          n_mismatch = 0, tests_run = 0, w = 0, cyc = 0;
  logic        sgl = 1'b0;
  logic [31:0] mem_rd_data = 32'h100, exp_w;

  dgc_top #(.ACTIVE_WORDS(28'h10)) dgc_top_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .synth_tick, .synth_locked, .ext_clk_pin, .fe_cfg,
    .adc_conv(), .adc_valid, .adc_smp, .trig_pin, .dio_i, .dio_o, .dio_oe,
    .mem_wr_valid, .mem_wr_data, .mem_wr_pkt(), .mem_rd_valid,
    .mem_rd_data, .mem_rd_ready, .offload_tx_valid(), .offload_tx_data(),
    .offload_rx_valid, .offload_rx_data, .offload_rx_ready(), .host_valid,
    .host_data, .host_ready, .mode);
  dgc_host_model dgc_host_model_inst (.pclk, .presetn, .slow(1'b1),
    .host_valid, .host_data, .host_ready, .n_rx, .last);

  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr_en, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Three edges let a setting reach fe_cfg and the connector pins.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask : wr

  task automatic samples(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      adc_valid <= 1'b1;
      adc_smp   <= '{ch0: 14'(i), ch1: 14'(i + 256)};
      @(posedge pclk);
      adc_valid <= 1'b0;
    end
  endtask : samples

  task automatic wait_mode(input dgc_mode_e m);
    for (int i = 0; i < 400 && mode !== m; i++)
      @(posedge pclk);
    // One more edge lets the last memory word be counted first.
    @(posedge pclk);
    check(32'(mode), 32'(m));
  endtask : wait_mode

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mem_rd_valid && mem_rd_ready === 1'b1)
      mem_rd_data <= mem_rd_data + 32'h1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end else if (mem_wr_valid === 1'b1) begin
      // Single mode at ratio 2 packs every other ch1 sample, two a word.
      exp_w = sgl ? {2'b00, 14'(4 * w + 194), 2'b00, 14'(4 * w + 192)}
                  : {2'b00, 14'(w + 256), 2'b00, 14'(w)};
      check(mem_wr_data, exp_w);
      w++;
    end
  end

  initial begin
    {psel, penable, pwrite, adc_valid, mem_rd_valid, dio_i, ext_clk_pin,
     trig_pin, offload_rx_valid, paddr, pwdata, adc_smp, offload_rx_data} = '0;
    // A locked synthesizer at a legal rate ticks on every cycle.
    {synth_tick, synth_locked} = 2'b11;
    {pclk, presetn} = 2'b00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_MODE, 32'h0);
    check(q, 32'h1);
    check(32'(fe_cfg.div), 32'(DIV_MIN));
    apb(1'b0, 12'h0FC, 32'h0);
    check(32'(e), 32'h1);
    check(q, 32'h0);
    wr(A_CLK, 32'h7C8);
    check(32'(fe_cfg.div), 32'(DIV_MAX));
    check(32'(fe_cfg.dsc), 32'(DSC_MAX));
    wr(A_CLK, 32'h6);
    check(32'(fe_cfg.div), 32'(DIV_MIN));
    check(32'({fe_cfg.clkin_ref, fe_cfg.ref_ext}), 32'h3);
    wr(A_CHAN, 32'h373);
    check(32'({fe_cfg.gain0, fe_cfg.gain1}), 32'({GAIN_MAX, 3'h3}));
    check(32'(fe_cfg.sel), 32'h1);
    wr(A_CHAN, 32'h1);
    wr(A_OFS, 32'h0ABC0123);
    check(32'({fe_cfg.ofs1, fe_cfg.ofs0}), 32'hABC123);
    for (int s = 0; s < 4; s += 3) begin
      wr(A_DIO, 32'(s << 1));
      check(32'({dio_oe, dio_o}), 32'({1'b1, s[0]}));
    end
    wr(A_DIO, 32'h1);
    check(32'(dio_oe), 32'h0);
    dio_i <= 1'b1;
    repeat (8) @(posedge pclk);
    dio_i <= 1'b0;
    apb(1'b0, A_STAT, 32'h0);
    check(32'(q[ST_TSREQ_B]), 32'h1);
    check(32'(q[ST_LOCK_B]), 32'h1);
    wr(A_STAT, 32'h40);
    apb(1'b0, A_STAT, 32'h0);
    check(32'(q[ST_TSREQ_B]), 32'h0);
    samples(4);
    check(w, 0);
    wr(A_MODE, 32'(M_RAM));
    check(32'(mode), 32'(M_RAM));
    wr(A_CLK, 32'h48);
    check(32'(fe_cfg.div), 32'(DIV_MIN));
    samples(16);
    wait_mode(M_STBY);
    check(w, 16);
    check(32'(n_rx), 32'h0);
    apb(1'b0, A_STAT, 32'h0);
    check(32'(q[ST_RDONE_B]), 32'h1);
    mem_rd_valid <= 1'b1;
    wr(A_MODE, 32'(M_XFER));
    wait_mode(M_STBY);
    repeat (4) @(posedge pclk);
    check(32'(n_rx), 32'h10);
    check(last, 32'h10F);
    // Single capture of channel two, keeping one sample in two.
    wr(A_CHAN, 32'h2);
    wr(A_CLK, 32'h108);
    check(32'(fe_cfg.dsc), 32'h1);
    sgl = 1'b1;
    wr(A_MODE, 32'(M_RAM));
    samples(64);
    wait_mode(M_STBY);
    check(w, 32);
    // Offload mode keeps samples out of memory and streams the answer.
    wr(A_MODE, 32'(M_OFFL));
    offload_rx_data  <= 32'h5A5A0001;
    offload_rx_valid <= 1'b1;
    samples(8);
    check(w, 32);
    check(last, 32'h5A5A0001);
    wr(A_MODE, 32'(M_STBY));
    check(32'(mode), 32'(M_STBY));
    stop_test();
  end
endmodule : dgc_top_tb
